// File: include/fsc_link_if.sv
// serial link between the host controller and the filter config port.
// assumes both ends sit on their own REF_CLK; serial_out is resolved here.
`timescale 1ns/1ns
interface fsc_link_if;
   logic sclk;
   logic serial_in;
   logic load_strobe;
   logic power_down_pin;
   logic serial_out_o;
   logic serial_out_oe_n;
   logic serial_out;

   // released line reads high, as a weak pull-up would leave it
   assign serial_out = serial_out_oe_n ? 1'b1 : serial_out_o;

   modport device (
      input sclk, serial_in, load_strobe, power_down_pin,
      output serial_out_o, serial_out_oe_n
   );
   modport host (
      output sclk, serial_in, load_strobe, power_down_pin,
      input serial_out
   );
endinterface : fsc_link_if

// File: include/fsc_pkg.sv
// constants shared by both ends of the filter serial configuration port.
// assumes a 20 MHz REF_CLK on both ends and a host-made serial clock.
//
// Overview of operation
// - device samples serial_in on falling clock edges
// - shift while load low; latch on load rise
// - frame: 3 address bits, 5 data bits, MSB first
// - address 000 is control; bits 2,1 meaningful
// - host writes control bit 0 as zero
// - control bit 1 enables continuous calibration, default one
// - control bit 2 zero means power-down, default one
// - address 110 starts one calibration if not continuous
// - address 001 holds zero A index, default 0
// - address 010 holds zero B index, default 0
// - scaling top bits select divisor, default code 01
// - scaling low bits scale index, default 01100 total
// - host reads via address 111 with target address
// - readback shifts address plus data on falling edges
// - host captures readback bits at the end of each high phase
// - serial_out released until load rises after readback request
// - ninth falling edge releases serial_out again
// - power-down pin low forces standby
package fsc_pkg;
   localparam int FRAME_BITS = 8;
   localparam int ADDR_W = 3;
   localparam int DATA_W = 5;
   localparam logic [3:0] RB_RELEASE_EDGE = 4'h9;
   localparam logic [3:0] RB_LAST_BIT = 4'h8;

   // register addresses
   localparam logic [2:0] ADDR_CTRL = 3'h0;
   localparam logic [2:0] ADDR_ZERO_A = 3'h1;
   localparam logic [2:0] ADDR_ZERO_B = 3'h2;
   localparam logic [2:0] ADDR_SCALING = 3'h5;
   localparam logic [2:0] ADDR_CAL = 3'h6;
   localparam logic [2:0] ADDR_READBACK = 3'h7;

   // control field positions and power-up values
   localparam int CTRL_ZERO_BIT = 0;
   localparam int CTRL_CAL_BIT = 1;
   localparam int CTRL_RUN_BIT = 2;
   localparam logic [4:0] CTRL_RESET = 5'h06;
   localparam logic [4:0] CTRL_RB_MASK = 5'h06;
   localparam logic [4:0] ZERO_RESET = 5'h00;
   localparam logic [4:0] SCALING_RESET = 5'h0C;

   // serial clock made by the host
   localparam int REF_CLK_NS = 50;
   localparam int SCLK_PERIOD_NS = 400;
   localparam int SCLK_HALF_CYC = SCLK_PERIOD_NS / (2 * REF_CLK_NS);
   localparam logic [3:0] HALF_LAST = 4'(SCLK_HALF_CYC - 1);

   // host command port registers
   localparam logic [1:0] HREG_CMD = 2'h0;
   localparam logic [1:0] HREG_STATUS = 2'h1;
   localparam logic [1:0] HREG_RBDATA = 2'h2;
   localparam logic [1:0] HREG_PINS = 2'h3;
   localparam int STAT_BUSY_BIT = 0;
   localparam int STAT_RBV_BIT = 1;
endpackage : fsc_pkg

// File: rtl/fsc_device.sv
// device end of the filter serial configuration port: shift, latch, readback.
// assumes sclk, serial_in, load_strobe and power_down_pin are asynchronous pins.
`timescale 1ns/1ns
module fsc_device
   import fsc_pkg::*;
(
   // clock and reset
   input wire logic REF_CLK,
   input wire logic RST_N,
   // serial link
   fsc_link_if.device LINK,
   // filter controls
   output logic CAL_CONT,
   output logic OPERATING,
   output logic STANDBY,
   output logic CAL_START,
   output logic [4:0] ZERO_A,
   output logic [4:0] ZERO_B,
   output logic [1:0] SCALE_DIV,
   output logic [2:0] SCALE_IDX
);
   typedef enum logic [0:0] {
      RB_IDLE = 1'b0,
      RB_SHIFT = 1'b1
   } fsc_rb_state_t;

   logic [3:0] pins_s;
   logic sclk_s;
   logic sdi_s;
   logic load_s;
   logic pdn_s;
   logic sclk_d_ff;
   logic load_d_ff;
   logic sclk_fall;
   logic load_rise;
   logic [FRAME_BITS-1:0] shift_ff;
   logic [ADDR_W-1:0] frame_addr;
   logic [DATA_W-1:0] frame_data;
   logic [4:0] ctrl_ff;
   logic [4:0] zero_a_ff;
   logic [4:0] zero_b_ff;
   logic [4:0] scaling_ff;
   logic [4:0] rb_word;
   fsc_rb_state_t rb_state_ff;
   fsc_rb_state_t nxt_rb_state;
   logic [FRAME_BITS-1:0] rb_shift_ff;
   logic [3:0] rb_cnt_ff;
   logic sdo_ff;
   logic sdo_oe_n_ff;

   // every pin passes two flops before use
   // idle levels: sclk low, serial_in low, load high, pin high
   fsc_sync #(
      .W(4),
      .RST_VAL(4'h3)
   ) u_sync (
      .clk(REF_CLK),
      .rst_n(RST_N),
      .d({LINK.sclk, LINK.serial_in, LINK.load_strobe, LINK.power_down_pin}),
      .q(pins_s)
   );

   assign sclk_s = pins_s[3];
   assign sdi_s = pins_s[2];
   assign load_s = pins_s[1];
   assign pdn_s = pins_s[0];

   // edge detection on the synchronised levels
   always_ff @(posedge REF_CLK) begin
      if (!RST_N) begin
         sclk_d_ff <= 1'b0;
         load_d_ff <= 1'b1;
      end else begin
         sclk_d_ff <= sclk_s;
         load_d_ff <= load_s;
      end
   end

   assign sclk_fall = sclk_d_ff && !sclk_s;
   assign load_rise = !load_d_ff && load_s;

   // input shifter; sdi shares sclk's latency so its setup is kept
   always_ff @(posedge REF_CLK) begin
      if (!RST_N) begin
         shift_ff <= '0;
      end else if (sclk_fall && !load_s) begin
         // oldest bits fall off the top, so extra leading bits are harmless
         shift_ff <= {shift_ff[FRAME_BITS-2:0], sdi_s};
      end
   end

   assign frame_addr = shift_ff[FRAME_BITS-1:DATA_W];
   assign frame_data = shift_ff[DATA_W-1:0];

   // control register; bit 0 kept at zero whatever the host sends
   always_ff @(posedge REF_CLK) begin
      if (!RST_N) begin
         ctrl_ff <= CTRL_RESET;
      end else if (load_rise && frame_addr == ADDR_CTRL) begin
         ctrl_ff <= '0;
         ctrl_ff[CTRL_CAL_BIT] <= frame_data[CTRL_CAL_BIT];
         ctrl_ff[CTRL_RUN_BIT] <= frame_data[CTRL_RUN_BIT];
         ctrl_ff[CTRL_ZERO_BIT] <= 1'b0;
      end
   end

   // slimmer zero indices; values above 20 are stored as sent
   always_ff @(posedge REF_CLK) begin
      if (!RST_N) begin
         zero_a_ff <= ZERO_RESET;
      end else if (load_rise && frame_addr == ADDR_ZERO_A) begin
         zero_a_ff <= frame_data;
      end
   end

   always_ff @(posedge REF_CLK) begin
      if (!RST_N) begin
         zero_b_ff <= ZERO_RESET;
      end else if (load_rise && frame_addr == ADDR_ZERO_B) begin
         zero_b_ff <= frame_data;
      end
   end

   // cutoff scaling: divisor code on top, scale index below
   always_ff @(posedge REF_CLK) begin
      if (!RST_N) begin
         scaling_ff <= SCALING_RESET;
      end else if (load_rise && frame_addr == ADDR_SCALING) begin
         scaling_ff <= frame_data;
      end
   end
   // addresses 011 and 100 match none of the decoders above

   // one-shot calibration, only when continuous calibration is off
   always_ff @(posedge REF_CLK) begin
      if (!RST_N) begin
         CAL_START <= 1'b0;
      end else begin
         CAL_START <= load_rise && frame_addr == ADDR_CAL
            && !ctrl_ff[CTRL_CAL_BIT];
      end
   end

   // readback word selection; unused bits read as zero
   always_comb begin
      unique case (frame_data[ADDR_W-1:0])
         ADDR_CTRL: rb_word = ctrl_ff & CTRL_RB_MASK;
         ADDR_ZERO_A: rb_word = zero_a_ff;
         ADDR_ZERO_B: rb_word = zero_b_ff;
         ADDR_SCALING: rb_word = scaling_ff;
         default: rb_word = '0;
      endcase
   end

   // readback sequencer
   always_comb begin
      nxt_rb_state = rb_state_ff;
      unique case (rb_state_ff)
         RB_IDLE: begin
            if (load_rise && frame_addr == ADDR_READBACK) begin
               nxt_rb_state = RB_SHIFT;
            end
         end
         RB_SHIFT: begin
            if (sclk_fall && rb_cnt_ff == RB_LAST_BIT) begin
               nxt_rb_state = RB_IDLE;
            end
         end
      endcase
   end

   always_ff @(posedge REF_CLK) begin
      if (!RST_N) begin
         rb_state_ff <= RB_IDLE;
      end else begin
         rb_state_ff <= nxt_rb_state;
      end
   end

   // falls 1..8 present bits 7..0; the ninth fall releases the line
   always_ff @(posedge REF_CLK) begin
      if (!RST_N) begin
         rb_shift_ff <= '0;
         rb_cnt_ff <= '0;
      end else if (rb_state_ff == RB_IDLE) begin
         rb_shift_ff <= {frame_data[ADDR_W-1:0], rb_word};
         rb_cnt_ff <= '0;
      end else if (sclk_fall) begin
         rb_shift_ff <= {rb_shift_ff[FRAME_BITS-2:0], 1'b0};
         rb_cnt_ff <= rb_cnt_ff + 4'h1;
      end
   end

   // serial_out driver; enable low while driving
   always_ff @(posedge REF_CLK) begin
      if (!RST_N) begin
         sdo_ff <= 1'b0;
         sdo_oe_n_ff <= 1'b1;
      end else if (rb_state_ff == RB_IDLE) begin
         sdo_ff <= 1'b0;
         sdo_oe_n_ff <= (nxt_rb_state == RB_IDLE);
      end else if (sclk_fall) begin
         if (rb_cnt_ff == RB_LAST_BIT) begin
            sdo_oe_n_ff <= 1'b1;
         end else begin
            sdo_ff <= rb_shift_ff[FRAME_BITS-1];
         end
      end
   end

   assign LINK.serial_out_o = sdo_ff;
   assign LINK.serial_out_oe_n = sdo_oe_n_ff;

   // filter-facing outputs, all registered
   always_ff @(posedge REF_CLK) begin
      if (!RST_N) begin
         CAL_CONT <= CTRL_RESET[CTRL_CAL_BIT];
         OPERATING <= 1'b0;
         STANDBY <= 1'b1;
         ZERO_A <= ZERO_RESET;
         ZERO_B <= ZERO_RESET;
         SCALE_DIV <= SCALING_RESET[4:3];
         SCALE_IDX <= SCALING_RESET[2:0];
      end else begin
         CAL_CONT <= ctrl_ff[CTRL_CAL_BIT];
         // a low pin overrides whatever the control register says
         OPERATING <= ctrl_ff[CTRL_RUN_BIT] && pdn_s;
         STANDBY <= !pdn_s || !ctrl_ff[CTRL_RUN_BIT];
         ZERO_A <= zero_a_ff;
         ZERO_B <= zero_b_ff;
         SCALE_DIV <= scaling_ff[4:3];
         SCALE_IDX <= scaling_ff[2:0];
      end
   end
endmodule : fsc_device

// File: rtl/fsc_host.sv
// host end: sends frames on command and collects readback words.
// assumes software on the plain register port; sclk made by a divider.
`timescale 1ns/1ns
module fsc_host
   import fsc_pkg::*;
(
   // clock and reset
   input wire logic REF_CLK,
   input wire logic RST_N,
   // serial link
   fsc_link_if.host LINK,
   // register port
   input wire logic [1:0] ADDR,
   input wire logic [7:0] WDATA,
   input wire logic WR,
   input wire logic RD,
   output logic [7:0] RDATA
);
   typedef enum logic [2:0] {
      H_IDLE = 3'b000,
      H_SETUP = 3'b001,
      H_HI = 3'b010,
      H_LO = 3'b011,
      H_LATCH = 3'b100,
      H_RB_HI = 3'b101,
      H_RB_LO = 3'b110
   } fsc_host_state_t;

   fsc_host_state_t state_ff;
   logic [3:0] tmr_ff;
   logic [3:0] bit_ff;
   logic [FRAME_BITS-1:0] tx_ff;
   logic [FRAME_BITS-1:0] rx_ff;
   logic [FRAME_BITS-1:0] rb_data_ff;
   logic rb_valid_ff;
   // remembers whether the frame in flight is a readback request
   logic rb_req_ff;
   logic sclk_ff;
   logic sdi_ff;
   logic load_ff;
   logic pdn_ff;
   logic sdo_s;
   logic half_done;
   logic start;

   // a released line reads high
   fsc_sync #(
      .W(1),
      .RST_VAL(1'h1)
   ) u_sync (
      .clk(REF_CLK),
      .rst_n(RST_N),
      .d(LINK.serial_out),
      .q(sdo_s)
   );

   assign half_done = (tmr_ff == HALF_LAST);
   // commands while busy are dropped
   assign start = WR && ADDR == HREG_CMD && state_ff == H_IDLE;

   always_ff @(posedge REF_CLK) begin
      if (!RST_N || state_ff == H_IDLE || half_done) begin
         tmr_ff <= '0;
      end else begin
         tmr_ff <= tmr_ff + 4'h1;
      end
   end

   // frame sequencer and pin drivers
   always_ff @(posedge REF_CLK) begin
      if (!RST_N) begin
         state_ff <= H_IDLE;
         sclk_ff <= 1'b0;
         sdi_ff <= 1'b0;
         load_ff <= 1'b1;
         bit_ff <= '0;
         tx_ff <= '0;
      end else begin
         unique case (state_ff)
            H_IDLE: begin
               if (start) begin
                  tx_ff <= WDATA;
                  load_ff <= 1'b0;
                  sdi_ff <= WDATA[FRAME_BITS-1];
                  bit_ff <= '0;
                  state_ff <= H_SETUP;
               end
            end
            H_SETUP, H_LO: begin
               if (half_done) begin
                  if (bit_ff == RB_LAST_BIT) begin
                     load_ff <= 1'b1;
                     state_ff <= H_LATCH;
                  end else begin
                     sdi_ff <= tx_ff[FRAME_BITS-1];
                     tx_ff <= {tx_ff[FRAME_BITS-2:0], 1'b0};
                     sclk_ff <= 1'b1;
                     state_ff <= H_HI;
                  end
               end
            end
            H_HI: begin
               if (half_done) begin
                  sclk_ff <= 1'b0;
                  bit_ff <= bit_ff + 4'h1;
                  state_ff <= H_LO;
               end
            end
            H_LATCH: begin
               if (half_done) begin
                  bit_ff <= '0;
                  if (rb_req_ff) begin
                     sclk_ff <= 1'b1;
                     state_ff <= H_RB_HI;
                  end else begin
                     state_ff <= H_IDLE;
                  end
               end
            end
            H_RB_HI: begin
               if (half_done) begin
                  sclk_ff <= 1'b0;
                  bit_ff <= bit_ff + 4'h1;
                  state_ff <= H_RB_LO;
               end
            end
            H_RB_LO: begin
               if (half_done) begin
                  if (bit_ff == RB_RELEASE_EDGE) begin
                     state_ff <= H_IDLE;
                  end else begin
                     sclk_ff <= 1'b1;
                     state_ff <= H_RB_HI;
                  end
               end
            end
            default: state_ff <= H_IDLE;
         endcase
      end
   end

   always_ff @(posedge REF_CLK) begin
      if (!RST_N) begin
         rb_req_ff <= 1'b0;
      end else if (start) begin
         rb_req_ff <= (WDATA[FRAME_BITS-1:DATA_W] == ADDR_READBACK);
      end
   end

   // capture late in the high phase: the sync lag hides the next change
   always_ff @(posedge REF_CLK) begin
      if (!RST_N) begin
         rx_ff <= '0;
      end else if (state_ff == H_RB_HI && half_done) begin
         rx_ff <= {rx_ff[FRAME_BITS-2:0], sdo_s};
      end
   end

   // readback result; a new event beats a software clear
   always_ff @(posedge REF_CLK) begin
      if (!RST_N) begin
         rb_data_ff <= '0;
         rb_valid_ff <= 1'b0;
      end else if (state_ff == H_RB_LO && half_done && bit_ff == RB_RELEASE_EDGE) begin
         rb_data_ff <= rx_ff;
         rb_valid_ff <= 1'b1;
      end else if (start || (RD && ADDR == HREG_RBDATA)) begin
         rb_valid_ff <= 1'b0;
      end
   end

   always_ff @(posedge REF_CLK) begin
      if (!RST_N) begin
         pdn_ff <= 1'b1;
      end else if (WR && ADDR == HREG_PINS) begin
         pdn_ff <= WDATA[0];
      end
   end

   always_ff @(posedge REF_CLK) begin
      if (!RST_N) begin
         RDATA <= '0;
      end else if (RD) begin
         unique case (ADDR)
            HREG_CMD: RDATA <= '0;
            HREG_STATUS: RDATA <= {6'h00, rb_valid_ff, state_ff != H_IDLE};
            HREG_RBDATA: RDATA <= rb_data_ff;
            HREG_PINS: RDATA <= {7'h00, pdn_ff};
         endcase
      end else begin
         RDATA <= '0;
      end
   end

   assign LINK.sclk = sclk_ff;
   assign LINK.serial_in = sdi_ff;
   assign LINK.load_strobe = load_ff;
   assign LINK.power_down_pin = pdn_ff;
endmodule : fsc_host

// File: rtl/fsc_sync.sv
// two flip-flop synchroniser for pin inputs.
// assumes inputs are levels; edges are found on the output by the user.
`timescale 1ns/1ns
module fsc_sync #(
   parameter int W = 1,
   parameter logic [W-1:0] RST_VAL = '0
) (
   // clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // pins
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);
   logic [W-1:0] meta_ff;

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         // reset to the pins' idle levels so no false edge follows reset
         meta_ff <= RST_VAL;
         q <= RST_VAL;
      end else begin
         meta_ff <= d;
         q <= meta_ff;
      end
   end
endmodule : fsc_sync

// File: sim/fsc_bench.sv
// bench: host end and device end joined by the link, driven by register port.
// assumes the host register map and timing given in the package.
`timescale 1ns/1ns
module fsc_bench;
   import fsc_pkg::*;
   logic ref_clk;
   logic rst_n;
   logic [1:0] addr;
   logic [7:0] wdata;
   logic wr;
   logic rd;
   logic [7:0] rdata;
   logic cal_cont, operating, standby, cal_start;
   logic [4:0] zero_a, zero_b;
   logic [1:0] scale_div;
   logic [2:0] scale_idx;
   logic [7:0] rd_v;
   logic sclk_q = 1'b0;
   logic hin = 1'b0;
   logic hout = 1'b0;
   logic [7:0] w_in = 8'h00;
   logic [7:0] w_out = 8'h00;
   int n_in = 0;
   int n_out = 0;
   int n_cal = 0;
   int n_errors = 0;
   int n_tests = 0;

   fsc_link_if fsc_link_if_i ();
   fsc_device fsc_device_i (.REF_CLK(ref_clk), .RST_N(rst_n), .LINK(fsc_link_if_i),
      .CAL_CONT(cal_cont), .OPERATING(operating), .STANDBY(standby), .CAL_START(cal_start),
      .ZERO_A(zero_a), .ZERO_B(zero_b), .SCALE_DIV(scale_div), .SCALE_IDX(scale_idx));
   fsc_host fsc_host_i (.REF_CLK(ref_clk), .RST_N(rst_n), .LINK(fsc_link_if_i),
      .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata));
   fsc_link_assertions fsc_link_assertions_i (.REF_CLK(ref_clk), .RST_N(rst_n),
      .sclk(fsc_link_if_i.sclk), .serial_in(fsc_link_if_i.serial_in),
      .load_strobe(fsc_link_if_i.load_strobe), .serial_out_o(fsc_link_if_i.serial_out_o),
      .serial_out_oe_n(fsc_link_if_i.serial_out_oe_n));

   initial begin
      ref_clk = 1'b0;
      forever #25 ref_clk = ~ref_clk;
   end

   // wire monitor: bits held from the high phase, shifted at each fall
   always @(posedge ref_clk) begin
      sclk_q <= fsc_link_if_i.sclk;
      if (fsc_link_if_i.sclk) begin
         hin <= fsc_link_if_i.serial_in;
         hout <= fsc_link_if_i.serial_out;
      end
      if (sclk_q && !fsc_link_if_i.sclk && !fsc_link_if_i.load_strobe) begin
         w_in <= {w_in[6:0], hin};
         n_in <= n_in + 1;
      end
      if (sclk_q && !fsc_link_if_i.sclk && fsc_link_if_i.load_strobe
         && !fsc_link_if_i.serial_out_oe_n) begin
         w_out <= {w_out[6:0], hout};
         n_out <= n_out + 1;
      end
      if (cal_start === 1'b1) n_cal <= n_cal + 1;
   end

   task automatic print_verdict;
      if (n_errors == 0 && n_tests > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask : print_verdict

   task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
      n_tests++;
      if (seen !== exp) begin
         n_errors++;
         $display("BAD %s expected %h seen %h", what, exp, seen);
      end
   endtask : chk

   task automatic wr_reg(input logic [1:0] a, input logic [7:0] d);
      @(posedge ref_clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge ref_clk);
      wr <= 1'b0;
   endtask : wr_reg

   task automatic rd_reg(input logic [1:0] a, output logic [7:0] d);
      @(posedge ref_clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge ref_clk);
      rd <= 1'b0;
      #1 d = rdata;
   endtask : rd_reg

   task automatic frame(input logic [2:0] a, input logic [4:0] d);
      int k;
      wr_reg(HREG_CMD, {a, d});
      n_in <= 0;
      n_out <= 0;
      k = 0;
      do begin
         rd_reg(HREG_STATUS, rd_v);
         k++;
      end while (rd_v[STAT_BUSY_BIT] !== 1'b0 && k < 300);
      chk("busy", {7'h00, rd_v[STAT_BUSY_BIT]}, 8'h00);
      repeat (6) @(posedge ref_clk);
      chk("frame bits", w_in, {a, d});
      chk("frame length", 8'(n_in), 8'h08);
   endtask : frame

   task automatic readback(input logic [2:0] a, input logic [7:0] exp);
      int k;
      frame(ADDR_READBACK, {2'b00, a});
      k = 0;
      do begin
         rd_reg(HREG_STATUS, rd_v);
         k++;
      end while (rd_v[STAT_RBV_BIT] !== 1'b1 && k < 300);
      chk("rb valid", {7'h00, rd_v[STAT_RBV_BIT]}, 8'h01);
      rd_reg(HREG_RBDATA, rd_v);
      chk("readback word", rd_v, exp);
      chk("wire word", w_out, exp);
      chk("wire pulses", 8'(n_out), 8'h09);
   endtask : readback

   task automatic chk_dev(input logic [4:0] za, input logic [4:0] zb, input logic [4:0] sc,
      input logic cc);
      chk("zero a", 8'(zero_a), 8'(za));
      chk("zero b", 8'(zero_b), 8'(zb));
      chk("scaling", 8'({scale_div, scale_idx}), 8'(sc));
      chk("cal cont", 8'(cal_cont), 8'(cc));
   endtask : chk_dev

   // watchdog sized well past the longest expected run
   initial begin
      repeat (30000) @(posedge ref_clk);
      n_errors++;
      print_verdict();
   end

   initial begin
      rst_n = 1'b0;
      addr = 2'h0;
      wdata = 8'h00;
      wr = 1'b0;
      rd = 1'b0;
      repeat (6) @(posedge ref_clk);
      rst_n <= 1'b1;
      repeat (6) @(posedge ref_clk);
      chk_dev(ZERO_RESET, ZERO_RESET, SCALING_RESET, 1'b1);
      chk("operating", 8'(operating), 8'h01);
      chk("standby", 8'(standby), 8'h00);
      readback(ADDR_CTRL, {ADDR_CTRL, CTRL_RESET});
      readback(ADDR_SCALING, {ADDR_SCALING, SCALING_RESET});
      // top legal index and one below
      frame(ADDR_ZERO_A, 5'h14);
      frame(ADDR_ZERO_B, 5'h13);
      readback(ADDR_ZERO_A, {ADDR_ZERO_A, 5'h14});
      readback(ADDR_ZERO_B, {ADDR_ZERO_B, 5'h13});
      for (int i = 0; i < 4; i++) begin
         frame(ADDR_SCALING, {2'(i), 3'(7 - i)});
         chk_dev(5'h14, 5'h13, {2'(i), 3'(7 - i)}, 1'b1);
      end
      readback(ADDR_SCALING, {ADDR_SCALING, 5'h1C});
      frame(3'h3, 5'h1F);
      frame(3'h4, 5'h00);
      chk_dev(5'h14, 5'h13, 5'h1C, 1'b1);
      // bit 0 set and ignored bits set: only bits 2 and 1 may land
      frame(ADDR_CTRL, 5'h1B);
      chk("operating", 8'(operating), 8'h00);
      chk("standby", 8'(standby), 8'h01);
      readback(ADDR_CTRL, {ADDR_CTRL, 5'h02});
      n_cal = 0;
      frame(ADDR_CAL, 5'h1F);
      chk("cal pulses", 8'(n_cal), 8'h00);
      frame(ADDR_CTRL, 5'h04);
      chk_dev(5'h14, 5'h13, 5'h1C, 1'b0);
      chk("operating", 8'(operating), 8'h01);
      frame(ADDR_CAL, 5'h00);
      chk("cal pulses", 8'(n_cal), 8'h01);
      frame(ADDR_CAL, 5'h15);
      chk("cal pulses", 8'(n_cal), 8'h02);
      // pin low overrides a control word that says run
      wr_reg(HREG_PINS, 8'h00);
      repeat (6) @(posedge ref_clk);
      chk("standby", 8'(standby), 8'h01);
      chk("operating", 8'(operating), 8'h00);
      rd_reg(HREG_PINS, rd_v);
      chk("pin level", {7'h00, rd_v[0]}, 8'h00);
      wr_reg(HREG_PINS, 8'h01);
      repeat (6) @(posedge ref_clk);
      chk("standby", 8'(standby), 8'h00);
      readback(ADDR_ZERO_B, {ADDR_ZERO_B, 5'h13});
      print_verdict();
   end
endmodule : fsc_bench

// File: sim/fsc_link_assertions.sv
// checker for the serial link between the host end and the device end.
// assumes it sits beside the link interface, with the device's REF_CLK.
`timescale 1ns/1ns
module fsc_link_assertions (
   // clock and reset
   input wire logic REF_CLK,
   input wire logic RST_N,
   // link signals
   input wire logic sclk,
   input wire logic serial_in,
   input wire logic load_strobe,
   input wire logic serial_out_o,
   input wire logic serial_out_oe_n
);
   logic sclk_ff;
   logic hold_ff;
   logic [7:0] frame_ff;
   logic [3:0] fcnt_ff;
   logic [3:0] rbcnt_ff;
   logic [3:0] since_ff;
   logic fall;

   assign fall = sclk_ff && !sclk;

   // data bit held from the high phase, so a change at the fall is not taken
   always_ff @(posedge REF_CLK) begin
      if (!RST_N) begin
         sclk_ff <= 1'b0;
         hold_ff <= 1'b0;
      end else begin
         sclk_ff <= sclk;
         if (sclk) hold_ff <= serial_in;
      end
   end

   always_ff @(posedge REF_CLK) begin
      if (!RST_N) frame_ff <= 8'h00;
      else if (fall && !load_strobe) frame_ff <= {frame_ff[6:0], hold_ff};
   end

   always_ff @(posedge REF_CLK) begin
      if (!RST_N || load_strobe) fcnt_ff <= 4'h0;
      else if (fall) fcnt_ff <= fcnt_ff + 4'h1;
   end

   always_ff @(posedge REF_CLK) begin
      if (!RST_N || serial_out_oe_n) rbcnt_ff <= 4'h0;
      else if (fall) rbcnt_ff <= rbcnt_ff + 4'h1;
   end

   // saturates so an idle link never wraps back into range
   always_ff @(posedge REF_CLK) begin
      if (!RST_N || fall) since_ff <= 4'h0;
      else if (since_ff != 4'hF) since_ff <= since_ff + 4'h1;
   end

   default clocking cb @(posedge REF_CLK);
   endclocking
   default disable iff (!RST_N);

   a_din_steady: assert property ($changed(serial_in) |-> !sclk || $rose(sclk))
      else $error("serial_in moved while sclk high");
   a_sclk_rest: assert property ($rose(load_strobe) |-> !sclk [*3])
      else $error("sclk not low at load rise");
   a_frame_eight: assert property ($rose(load_strobe) |-> fcnt_ff == 4'h8)
      else $error("frame not eight bits");
   a_quiet_shift: assert property (!load_strobe |-> serial_out_oe_n)
      else $error("serial_out driven in a frame");
   a_drive_after_rb: assert property ($rose(load_strobe) && frame_ff[7:5] == 3'h7
      |-> ##[1:6] !serial_out_oe_n)
      else $error("readback not driven");
   a_quiet_other: assert property ($rose(load_strobe) && frame_ff[7:5] != 3'h7
      |-> serial_out_oe_n [*8])
      else $error("serial_out driven after write");
   a_release_ninth: assert property ($rose(serial_out_oe_n) |-> rbcnt_ff == 4'h9)
      else $error("release not at ninth fall");
   a_drive_limit: assert property (!serial_out_oe_n |-> rbcnt_ff <= 4'h9)
      else $error("serial_out held past ninth fall");
   a_out_on_fall: assert property (!serial_out_oe_n && $past(serial_out_oe_n) == 1'b0
      && $changed(serial_out_o) |-> since_ff <= 4'h5)
      else $error("serial_out changed away from a fall");

   c_write: cover property ($rose(load_strobe) && frame_ff[7:5] != 3'h7);
   c_readback: cover property ($rose(load_strobe) && frame_ff[7:5] == 3'h7);
   c_release: cover property ($rose(serial_out_oe_n));
endmodule : fsc_link_assertions
